// ### common/alu_consts.vh
`ifndef ALU_CONSTS_VH
`define ALU_CONSTS_VH

// instruction word fields
`define FLD_OP_HI 15
`define FLD_OP_LO 10
`define FLD_TOP5_LO 11
`define FLD_DST_HI 9
`define FLD_DST_LO 7
`define FLD_PAIR_HI 6
`define FLD_PAIR_LO 4
`define FLD_CNT_HI 3
`define FLD_CNT_LO 0

// opcodes
`define OPC_SHIMM 6'h17
`define SUB_SHIMM 3'h2
`define OPC_SHREG2 6'h1f
`define SUB_SHREG2 4'h9
`define OPC_SHREG3 6'h1d
`define SUB_SHREG3 4'h2
`define OPC_MAC 6'h1a
`define SUB_MAC 2'h0
`define OPC_MACN 6'h1b
`define SUB_MACN 2'h2
`define OPC_MDUAL 6'h19
`define OPC_MV_WR 5'h01
`define OPC_MV_WRN 5'h02
`define OPC_MV_RD 5'h05
`define OPC_MV_RDN 5'h06

// register ids: 0..3 full accumulators, 8..9 upper word only
`define ID_A 4'h0
`define ID_B 4'h1
`define ID_C 4'h2
`define ID_X0 4'h4
`define ID_Y0 4'h5
`define ID_Y1 4'h6
`define ID_NONE 4'h7
`define ID_UPPER 4'h8
`define ID_A1 4'h8
`define ID_B1 4'h9

// condition code bits
`define CC_V 1
`define CC_Z 2
`define CC_N 3
`define CC_U 4
`define CC_E 5
`define CC_L 6
`define CCR_RESET 8'h00
`define MODE_EXEC_DM 0
`define MODE_RESET 1'b0
`define ACC_RESET 36'h000000000
`define GPR_RESET 16'h0000

// interrupt events
`define EV_ILLEGAL 0
`define EV_OVF 1
`define EV_CONFLICT 2
`define EV_EXEC_DM 3
`define EV_COUNT 4
`define IRQ_RESET 4'h0

// apb byte offsets
`define OFS_MODE 8'h00
`define OFS_CCR 8'h04
`define OFS_IRQ_ST 8'h08
`define OFS_IRQ_CLR 8'h0c
`define OFS_IRQ_EN 8'h10
`define OFS_X0 8'h14
`define OFS_Y0 8'h18
`define OFS_Y1 8'h1c
`define OFS_ACC_BLK 3'h1

// every instruction form completes in this many cycles; a dual read with exec_dm_reg set is blocked and never completes
`define EXEC_CYCLES 1

`endif

// ### rtl/word_shifter.v
`timescale 1ns/1ns

module word_shifter (
   input wire [15:0] value,
   input wire [3:0] count,
   output wire [15:0] result,
   output wire result_neg,
   output wire result_zero
);

   // logical: zeros enter from the top
   assign result = value >> count;
   assign result_neg = result[15];
   assign result_zero = ~|result;

endmodule // word_shifter

// ### rtl/frac_mac.v
`timescale 1ns/1ns

module frac_mac (
   input wire [15:0] src1,
   input wire [15:0] src2,
   input wire [35:0] addend,
   input wire negate,
   output wire [35:0] sum,
   output wire overflow
);

   wire signed [31:0] prod;
   wire [31:0] frac;
   wire [35:0] ext;
   wire [35:0] term;

   assign prod = $signed(src1) * $signed(src2);
   // fractional product drops the duplicate sign bit
   assign frac = {prod[30:0], 1'b0};
   assign ext = {{4{frac[31]}}, frac};
   assign term = negate ? (36'h000000000 - ext) : ext;
   assign sum = addend + term;
   assign overflow = (addend[35] == term[35]) & (sum[35] != addend[35]);

endmodule // frac_mac

// ### rtl/shift_mac_alu.v
`timescale 1ns/1ns
`include "alu_consts.vh"

module shift_mac_alu (
   input wire pclk,
   input wire presetn,
   input wire [7:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output wire pready,
   output wire [31:0] prdata,
   output wire pslverr,
   input wire instr_valid,
   input wire [15:0] instr_word,
   input wire [15:0] mem_rd_data0,
   input wire [15:0] mem_rd_data1,
   output wire mem_wr_valid,
   output wire [15:0] mem_wr_data,
   output wire instr_done,
   output wire [7:0] cond_codes,
   output wire irq
);

   wire [15:0] rd16 [0:7];
   wire [35:0] acc_rd [0:3];

   reg exec_dm_reg;
   reg [7:0] ccr_reg;
   reg [7:0] ccr_next;
   reg [3:0] irq_st_reg;
   reg [3:0] irq_en_reg;
   wire [3:0] irq_st_next;
   reg [3:0] ev;
   reg [31:0] prdata_reg;
   reg mem_wr_valid_reg;
   reg [15:0] mem_wr_data_reg;
   reg instr_done_reg;

   reg dec_shift;
   reg dec_mac;
   reg dec_neg;
   reg dec_rd;
   reg dec_wr;
   reg dec_dual;
   reg dec_ill;
   reg cnt_imm;
   reg [3:0] dst_id;
   reg [3:0] val_id;
   reg [3:0] cnt_id;
   reg [3:0] s1_id;
   reg [3:0] s2_id;
   reg [3:0] mv_id;
   reg [3:0] rd2_id;
   reg [7:0] pq;
   reg [7:0] pd;

   reg [3:0] wen;
   reg [15:0] wid;
   reg [143:0] wval;

   reg addr_hit;
   reg [31:0] rd_word;

   wire [5:0] op;
   wire [4:0] top5;
   wire [3:0] fff_id;
   wire dual_blocked;
   wire conflict;
   wire run;
   wire dst_is_acc;
   wire [15:0] sh_val;
   wire [3:0] sh_cnt;
   wire [15:0] sh_res;
   wire sh_neg;
   wire sh_zero;
   wire [35:0] addend;
   wire [35:0] mac_sum;
   wire mac_ovf;
   wire [4:0] mac_ext;
   wire apb_setup;
   wire apb_wr;
   wire clr_wr;

   function [7:0] pair3;
      input [2:0] q;
      begin
         case (q)
            3'h0: pair3 = {`ID_Y1, `ID_X0};
            3'h1: pair3 = {`ID_Y0, `ID_X0};
            3'h2: pair3 = {`ID_Y1, `ID_Y0};
            3'h3: pair3 = {`ID_Y0, `ID_Y0};
            3'h4: pair3 = {`ID_A, `ID_Y0};
            3'h5: pair3 = {`ID_B, `ID_Y1};
            3'h6: pair3 = {`ID_C, `ID_Y0};
            default: pair3 = {`ID_C, `ID_Y1};
         endcase
      end
   endfunction

   function [7:0] pair2;
      input [1:0] q;
      begin
         case (q)
            2'h0: pair2 = {`ID_Y1, `ID_X0};
            2'h1: pair2 = {`ID_Y1, `ID_Y0};
            2'h2: pair2 = {`ID_Y0, `ID_X0};
            default: pair2 = {`ID_C, `ID_Y0};
         endcase
      end
   endfunction

   function [3:0] j_id;
      input [1:0] j;
      begin
         case (j)
            2'h0: j_id = `ID_X0;
            2'h1: j_id = `ID_Y0;
            2'h2: j_id = `ID_Y1;
            default: j_id = `ID_C;
         endcase
      end
   endfunction

   function [3:0] ggg_id;
      input [2:0] g;
      begin
         case (g)
            3'h0: ggg_id = `ID_X0;
            3'h1: ggg_id = `ID_Y1;
            3'h2: ggg_id = `ID_Y0;
            3'h3: ggg_id = `ID_A;
            3'h4: ggg_id = `ID_B;
            3'h5: ggg_id = `ID_C;
            3'h6: ggg_id = `ID_A1;
            default: ggg_id = `ID_B1;
         endcase
      end
   endfunction

   // word into accumulator form: sign extension, word, zero low portion
   function [35:0] acc_of16;
      input [15:0] d;
      begin
         acc_of16 = {{4{d[15]}}, d, 16'h0000};
      end
   endfunction

   function [35:0] wr_val;
      input [3:0] id;
      input [15:0] d;
      begin
         if (id[3:2] == 2'b00)
            wr_val = acc_of16(d);
         else
            wr_val = {20'h00000, d};
      end
   endfunction

   assign op = instr_word[`FLD_OP_HI:`FLD_OP_LO];
   assign top5 = instr_word[`FLD_OP_HI:`FLD_TOP5_LO];
   assign fff_id = {1'b0, instr_word[`FLD_DST_HI:`FLD_DST_LO]};

   always @* begin
      dec_shift = 1'b0;
      dec_mac = 1'b0;
      dec_neg = 1'b0;
      dec_rd = 1'b0;
      dec_wr = 1'b0;
      dec_dual = 1'b0;
      dec_ill = 1'b0;
      cnt_imm = 1'b0;
      dst_id = `ID_A;
      val_id = `ID_A;
      cnt_id = `ID_A;
      s1_id = `ID_X0;
      s2_id = `ID_X0;
      mv_id = `ID_X0;
      rd2_id = `ID_X0;
      pq = pair3(instr_word[`FLD_PAIR_HI:`FLD_PAIR_LO]);
      pd = pair2(instr_word[5:4]);
      if (!instr_valid) begin
         dec_ill = 1'b0;
      end else if (op == `OPC_SHIMM && instr_word[6:4] == `SUB_SHIMM) begin
         dec_shift = 1'b1;
         dst_id = fff_id;
         val_id = fff_id;
         cnt_imm = 1'b1;
      end else if (op == `OPC_SHREG2 && instr_word[3:0] == `SUB_SHREG2) begin
         dec_shift = 1'b1;
         dst_id = fff_id;
         val_id = fff_id;
         cnt_id = {1'b0, instr_word[6:4]};
         dec_ill = (cnt_id == `ID_NONE);
      end else if (op == `OPC_SHREG3 && instr_word[3:0] == `SUB_SHREG3) begin
         dec_shift = 1'b1;
         dst_id = fff_id;
         val_id = pq[7:4];
         cnt_id = pq[3:0];
      end else if ((op == `OPC_MAC && instr_word[1:0] == `SUB_MAC) ||
                   (op == `OPC_MACN && instr_word[1:0] == `SUB_MACN)) begin
         dec_mac = 1'b1;
         dec_neg = (op == `OPC_MACN);
         dst_id = fff_id;
         s1_id = {1'b0, instr_word[6:4]};
         s2_id = j_id(instr_word[3:2]);
         dec_ill = (s1_id == `ID_NONE);
      end else if (op == `OPC_MDUAL && instr_word[3] && !instr_word[1]) begin
         dec_mac = 1'b1;
         dec_dual = 1'b1;
         dst_id = instr_word[7] ? `ID_B : `ID_A;
         s1_id = pd[7:4];
         s2_id = pd[3:0];
         mv_id = instr_word[9] ? `ID_Y1 : `ID_Y0;
         rd2_id = (instr_word[9:8] == 2'b11) ? `ID_C : `ID_X0;
      end else if (instr_word[3] && (top5 == `OPC_MV_WR || top5 == `OPC_MV_WRN ||
                   top5 == `OPC_MV_RD || top5 == `OPC_MV_RDN)) begin
         dec_mac = 1'b1;
         dec_neg = (top5 == `OPC_MV_WRN || top5 == `OPC_MV_RDN);
         dst_id = instr_word[7] ? `ID_B : `ID_A;
         s1_id = pq[7:4];
         s2_id = pq[3:0];
         mv_id = ggg_id(instr_word[10:8]);
         dec_rd = top5[2];
         dec_wr = ~top5[2];
      end else begin
         dec_ill = 1'b1;
      end
      if (dst_id == `ID_NONE)
         dec_ill = 1'b1;
   end

   // dual reads cannot be honoured while fetching from data memory
   assign dual_blocked = dec_dual & exec_dm_reg & ~dec_ill;
   // a read aimed at the arithmetic destination is dropped, the alu result stands
   assign conflict = dec_rd & (mv_id[3] | ~mv_id[2]) & (mv_id[1:0] == dst_id[1:0]);
   assign run = ~dec_ill & ~dual_blocked;
   assign dst_is_acc = ~dst_id[2];

   assign sh_val = rd16[val_id[2:0]];
   assign sh_cnt = cnt_imm ? instr_word[`FLD_CNT_HI:`FLD_CNT_LO] : rd16[cnt_id[2:0]][3:0];

   word_shifter u_shift (
      .value(sh_val),
      .count(sh_cnt),
      .result(sh_res),
      .result_neg(sh_neg),
      .result_zero(sh_zero)
   );

   // word destinations join at 36 bits as sign, word, zero low portion
   assign addend = dst_is_acc ? acc_rd[dst_id[1:0]] : acc_of16(rd16[dst_id[2:0]]);

   frac_mac u_mac (
      .src1(rd16[s1_id[2:0]]),
      .src2(rd16[s2_id[2:0]]),
      .addend(addend),
      .negate(dec_neg),
      .sum(mac_sum),
      .overflow(mac_ovf)
   );

   assign mac_ext = mac_sum[35:31];

   // write ports: 0 alu, 1 first read, 2 second read, 3 software; lower port wins
   always @* begin
      wen = 4'h0;
      wid = 16'h0000;
      wval = 144'h0;
      wen[0] = run & (dec_shift | dec_mac);
      wid[3:0] = dst_id;
      if (dec_shift)
         wval[35:0] = dst_is_acc ? acc_of16(sh_res) : {20'h00000, sh_res};
      else if (dst_is_acc)
         wval[35:0] = mac_sum;
      else
         wval[35:0] = {20'h00000, mac_sum[31:16]};
      wen[1] = run & ((dec_rd & ~conflict) | dec_dual);
      wid[7:4] = mv_id;
      wval[71:36] = wr_val(mv_id, mem_rd_data0);
      wen[2] = run & dec_dual;
      wid[11:8] = rd2_id;
      wval[107:72] = wr_val(rd2_id, mem_rd_data1);
      wen[3] = apb_wr & (paddr == `OFS_X0 || paddr == `OFS_Y0 || paddr == `OFS_Y1);
      wid[15:12] = (paddr == `OFS_X0) ? `ID_X0 : ((paddr == `OFS_Y0) ? `ID_Y0 : `ID_Y1);
      wval[143:108] = {20'h00000, pwdata[15:0]};
   end

   genvar k;
   generate
      for (k = 0; k < 4; k = k + 1) begin : g_acc
         localparam [31:0] K_IDX = k;
         localparam [31:0] K_UP = `ID_UPPER + k;
         localparam [3:0] FULL_ID = K_IDX[3:0];
         localparam [3:0] UP_ID = K_UP[3:0];
         reg [35:0] val_reg;
         reg [35:0] val_next;
         integer p;
         always @* begin
            val_next = val_reg;
            for (p = 3; p >= 0; p = p - 1) begin
               if (wen[p] && wid[p*4 +: 4] == FULL_ID)
                  val_next = wval[p*36 +: 36];
               else if (wen[p] && wid[p*4 +: 4] == UP_ID)
                  val_next = {val_reg[35:32], wval[p*36 +: 16], val_reg[15:0]};
            end
         end
         always @(posedge pclk or negedge presetn) begin
            if (!presetn)
               val_reg <= `ACC_RESET;
            else
               val_reg <= val_next;
         end
         assign acc_rd[k] = val_reg;
         assign rd16[k] = val_reg[31:16];
      end
      for (k = 0; k < 3; k = k + 1) begin : g_gpr
         localparam [31:0] G_IDX = `ID_X0 + k;
         localparam [3:0] GID = G_IDX[3:0];
         reg [15:0] val_reg;
         reg [15:0] val_next;
         integer p;
         always @* begin
            val_next = val_reg;
            for (p = 3; p >= 0; p = p - 1) begin
               if (wen[p] && wid[p*4 +: 4] == GID)
                  val_next = wval[p*36 +: 16];
            end
         end
         always @(posedge pclk or negedge presetn) begin
            if (!presetn)
               val_reg <= `GPR_RESET;
            else
               val_reg <= val_next;
         end
         assign rd16[k+4] = val_reg;
      end
      for (k = 0; k < `EV_COUNT; k = k + 1) begin : g_irq
         // a new event beats a software clear in the same cycle
         assign irq_st_next[k] = ev[k] | (irq_st_reg[k] & ~(clr_wr & pwdata[k]));
      end
   endgenerate

   assign rd16[7] = 16'h0000;

   always @* begin
      ccr_next = ccr_reg;
      if (apb_wr && paddr == `OFS_CCR)
         ccr_next = pwdata[7:0];
      if (wen[0] && dec_shift) begin
         ccr_next[`CC_N] = sh_neg;
         ccr_next[`CC_Z] = sh_zero;
      end
      if (wen[0] && dec_mac) begin
         ccr_next[`CC_L] = ccr_next[`CC_L] | mac_ovf;
         ccr_next[`CC_E] = ~(&mac_ext | ~|mac_ext);
         ccr_next[`CC_U] = ~(mac_sum[31] ^ mac_sum[30]);
         ccr_next[`CC_N] = mac_sum[35];
         ccr_next[`CC_Z] = ~|mac_sum;
         ccr_next[`CC_V] = mac_ovf;
      end
   end

   always @* begin
      ev = 4'h0;
      ev[`EV_ILLEGAL] = dec_ill;
      ev[`EV_OVF] = wen[0] & dec_mac & mac_ovf;
      ev[`EV_CONFLICT] = run & conflict;
      ev[`EV_EXEC_DM] = dual_blocked;
   end

   assign apb_setup = psel & ~penable;
   assign apb_wr = psel & penable & pwrite & addr_hit;
   assign clr_wr = apb_wr & (paddr == `OFS_IRQ_CLR);

   always @* begin
      addr_hit = 1'b1;
      rd_word = 32'h00000000;
      case (paddr)
         `OFS_MODE: rd_word[`MODE_EXEC_DM] = exec_dm_reg;
         `OFS_CCR: rd_word[7:0] = ccr_reg;
         `OFS_IRQ_ST: rd_word[3:0] = irq_st_reg;
         `OFS_IRQ_CLR: rd_word = 32'h00000000;
         `OFS_IRQ_EN: rd_word[3:0] = irq_en_reg;
         `OFS_X0: rd_word[15:0] = rd16[4];
         `OFS_Y0: rd_word[15:0] = rd16[5];
         `OFS_Y1: rd_word[15:0] = rd16[6];
         default: begin
            if (paddr[7:5] == `OFS_ACC_BLK && paddr[1:0] == 2'b00) begin
               if (paddr[2])
                  rd_word[3:0] = acc_rd[paddr[4:3]][35:32];
               else
                  rd_word = acc_rd[paddr[4:3]][31:0];
            end else begin
               addr_hit = 1'b0;
            end
         end
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exec_dm_reg <= `MODE_RESET;
         ccr_reg <= `CCR_RESET;
         irq_st_reg <= `IRQ_RESET;
         irq_en_reg <= `IRQ_RESET;
         prdata_reg <= 32'h00000000;
         mem_wr_valid_reg <= 1'b0;
         mem_wr_data_reg <= 16'h0000;
         instr_done_reg <= 1'b0;
      end else begin
         if (apb_wr && paddr == `OFS_MODE)
            exec_dm_reg <= pwdata[`MODE_EXEC_DM];
         if (apb_wr && paddr == `OFS_IRQ_EN)
            irq_en_reg <= pwdata[3:0];
         // read data is captured in the setup phase so the access needs no wait
         if (apb_setup && !pwrite)
            prdata_reg <= rd_word;
         ccr_reg <= ccr_next;
         irq_st_reg <= irq_st_next;
         mem_wr_valid_reg <= run & dec_wr;
         if (run && dec_wr)
            mem_wr_data_reg <= rd16[mv_id[2:0]];
         instr_done_reg <= wen[0];
      end
   end

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_hit;
   assign prdata = prdata_reg;
   assign mem_wr_valid = mem_wr_valid_reg;
   assign mem_wr_data = mem_wr_data_reg;
   assign instr_done = instr_done_reg;
   assign cond_codes = ccr_reg;
   assign irq = |(irq_st_reg & irq_en_reg);

endmodule // shift_mac_alu

// ### verif/shift_mac_alu_chk.sv
`timescale 1ns/1ns
`include "alu_consts.vh"
module shift_mac_alu_chk (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire instr_valid,
   input wire [15:0] instr_word,
   input wire instr_done,
   input wire mem_wr_valid,
   input wire [7:0] cond_codes,
   input wire irq
);
   wire [2:0] dst = instr_word[9:7];
   wire [5:0] opc = instr_word[15:10];
   wire ok_dst = dst != 3'h7;
   wire sh_imm = instr_valid && opc == `OPC_SHIMM && instr_word[6:4] == `SUB_SHIMM && ok_dst;
   wire sh_two = instr_valid && opc == `OPC_SHREG2 && instr_word[3:0] == `SUB_SHREG2 &&
      instr_word[6:4] != 3'h7 && ok_dst;
   wire sh_three = instr_valid && opc == `OPC_SHREG3 && instr_word[3:0] == `SUB_SHREG3 && ok_dst;
   wire mac_plus = opc == `OPC_MAC && instr_word[1:0] == `SUB_MAC;
   wire mac_minus = opc == `OPC_MACN && instr_word[1:0] == `SUB_MACN;
   wire mac = instr_valid && (mac_plus || mac_minus) && ok_dst && instr_word[6:4] != 3'h7;
   wire mv_wr = instr_valid && (instr_word[15:11] == `OPC_MV_WR || instr_word[15:11] == `OPC_MV_WRN);
   wire apb_wr = psel && penable && pwrite;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_imm_done; sh_imm |=> instr_done; endproperty
   a_imm_done: assert property (p_imm_done) else $error("imm shift not done");
   property p_two_done; sh_two |=> instr_done; endproperty
   a_two_done: assert property (p_two_done) else $error("reg shift not done");
   property p_three_done; sh_three |=> instr_done; endproperty
   a_three_done: assert property (p_three_done) else $error("3-op shift not done");
   property p_mac_done; mac |=> instr_done; endproperty
   a_mac_done: assert property (p_mac_done) else $error("mac not done");
   property p_done_cause; instr_done |-> $past(instr_valid); endproperty
   a_done_cause: assert property (p_done_cause) else $error("done without instr");
   property p_wr_cause; mem_wr_valid |-> $past(mv_wr); endproperty
   a_wr_cause: assert property (p_wr_cause) else $error("stray memory write");
   property p_shift_n; sh_imm && instr_word[3:0] != 4'h0 |=> !cond_codes[`CC_N]; endproperty
   a_shift_n: assert property (p_shift_n) else $error("negative after shift");
   property p_cc_hold; !$past(instr_valid) && !$past(apb_wr) |-> $stable(cond_codes); endproperty
   a_cc_hold: assert property (p_cc_hold) else $error("flags moved idle");
   property p_irq_hold; !$past(instr_valid) && !$past(apb_wr) |-> $stable(irq); endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq moved idle");
endmodule // shift_mac_alu_chk

bind shift_mac_alu shift_mac_alu_chk i_chk (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .instr_valid(instr_valid),
   .instr_word(instr_word),
   .instr_done(instr_done),
   .mem_wr_valid(mem_wr_valid),
   .cond_codes(cond_codes),
   .irq(irq)
);

// ### verif/core_feed.sv
`timescale 1ns/1ns
module core_feed (
   input wire pclk,
   output logic instr_valid,
   output logic [15:0] instr_word,
   output logic [15:0] mem_rd_data0,
   output logic [15:0] mem_rd_data1
);
   initial begin
      instr_valid = 1'b0;
      instr_word = 16'h0000;
      mem_rd_data0 = 16'h0000;
      mem_rd_data1 = 16'h0000;
   end
   // words pass unchanged so a caller may break read-target and xp limits
   task issue(input logic [15:0] w, input logic [15:0] d0, input logic [15:0] d1);
      @(posedge pclk);
      instr_valid <= 1'b1;
      instr_word <= w;
      mem_rd_data0 <= d0;
      mem_rd_data1 <= d1;
      @(posedge pclk);
      // memory data is stale once taken, so show its inverse
      instr_valid <= 1'b0;
      instr_word <= ~w;
      mem_rd_data0 <= ~d0;
      mem_rd_data1 <= ~d1;
   endtask
endmodule // core_feed

// ### verif/testbench.sv
`timescale 1ns/1ns
`include "alu_consts.vh"
module testbench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h00000000;
   wire pready, pslverr, instr_valid, mem_wr_valid, instr_done, irq;
   wire [31:0] prdata;
   wire [15:0] instr_word, mem_rd_data0, mem_rd_data1, mem_wr_data;
   wire [7:0] cond_codes;
   logic [31:0] rdat;
   logic rerr;
   int miscompares = 0;
   int n_compared = 0;
   always #25 pclk = ~pclk;
   shift_mac_alu i_shift_mac_alu (
      .pclk(pclk),
      .presetn(presetn),
      .paddr(paddr),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .pwdata(pwdata),
      .pready(pready),
      .prdata(prdata),
      .pslverr(pslverr),
      .instr_valid(instr_valid),
      .instr_word(instr_word),
      .mem_rd_data0(mem_rd_data0),
      .mem_rd_data1(mem_rd_data1),
      .mem_wr_valid(mem_wr_valid),
      .mem_wr_data(mem_wr_data),
      .instr_done(instr_done),
      .cond_codes(cond_codes),
      .irq(irq)
   );
   core_feed i_core_feed (
      .pclk(pclk),
      .instr_valid(instr_valid),
      .instr_word(instr_word),
      .mem_rd_data0(mem_rd_data0),
      .mem_rd_data1(mem_rd_data1)
   );
   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [35:0] got, input logic [35:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h00000000);
      chk({4'h0, rdat}, {4'h0, e});
   endtask
   // done is looked at in the cycle after the executing edge, once its updates land
   task ex(input logic [15:0] w, input logic [15:0] d0, input logic [15:0] d1, input logic dn);
      i_core_feed.issue(w, d0, d1);
      #1;
      chk({35'h0, instr_done}, {35'h0, dn});
   endtask
   initial begin
      #100000;
      miscompares++;
      wrap_up;
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      wr(`OFS_Y1, 32'h0000aaaa);
      wr(`OFS_Y0, 32'h00000001);
      wr(`OFS_X0, 32'h00000000);
      ex(16'h7422, 16'h0000, 16'h0000, 1'b1);
      rd(8'h20, 32'h55550000);
      rd(8'h24, 32'h00000000);
      ex(16'h7482, 16'h0000, 16'h0000, 1'b1);
      chk({34'h0, cond_codes[3:2]}, 36'h2);
      rd(8'h28, 32'haaaa0000);
      rd(8'h2c, 32'h0000000f);
      ex(16'h7542, 16'h0000, 16'h0000, 1'b1);
      rd(8'h30, 32'h2aaa0000);
      $display("test three-operand shift done");
      ex(16'h5ca4, 16'h0000, 16'h0000, 1'b1);
      rd(8'h28, 32'h0aaa0000);
      rd(8'h2c, 32'h00000000);
      wr(`OFS_X0, 32'h00008000);
      ex(16'h5e2f, 16'h0000, 16'h0000, 1'b1);
      rd(`OFS_X0, 32'h00000001);
      ex(16'h5e21, 16'h0000, 16'h0000, 1'b1);
      chk({34'h0, cond_codes[3:2]}, 36'h1);
      wr(`OFS_Y1, 32'h0000fff3);
      wr(`OFS_Y0, 32'h00008000);
      ex(16'h7ee9, 16'h0000, 16'h0000, 1'b1);
      rd(`OFS_Y0, 32'h00001000);
      ex(16'h5fa0, 16'h0000, 16'h0000, 1'b0);
      $display("test immediate and register shift done");
      wr(`OFS_X0, 32'h00000280);
      wr(`OFS_Y0, 32'h00000200);
      ex(16'h6850, 16'h0000, 16'h0000, 1'b1);
      rd(8'h20, 32'h555f0000);
      ex(16'h6c52, 16'h0000, 16'h0000, 1'b1);
      rd(8'h20, 32'h55550000);
      wr(`OFS_X0, 32'h0000fd80);
      wr(`OFS_Y1, 32'h00000001);
      ex(16'h6b50, 16'h0000, 16'h0000, 1'b1);
      chk({33'h0, cond_codes[3:1]}, 36'h4);
      rd(`OFS_Y1, 32'h0000fff7);
      wr(`OFS_X0, 32'h00004000);
      wr(`OFS_Y0, 32'h00004000);
      ex(16'h6850, 16'h0000, 16'h0000, 1'b1);
      ex(16'h6850, 16'h0000, 16'h0000, 1'b1);
      chk({35'h0, cond_codes[`CC_E]}, 36'h1);
      chk({34'h0, cond_codes[3], cond_codes[1]}, 36'h0);
      rd(8'h20, 32'h95550000);
      rd(8'h24, 32'h00000000);
      $display("test multiply-accumulate done");
      ex(16'h0808, 16'h0000, 16'h0000, 1'b1);
      chk({35'h0, mem_wr_valid}, 36'h1);
      chk({20'h0, mem_wr_data}, 36'h4000);
      rd(8'h20, 32'h95508000);
      ex(16'h2808, 16'h1234, 16'h0000, 1'b1);
      rd(`OFS_X0, 32'h00001234);
      ex(16'h2b08, 16'h7777, 16'h0000, 1'b1);
      wr(`OFS_IRQ_EN, 32'h00000004);
      #1;
      chk({35'h0, irq}, 36'h1);
      rd(`OFS_IRQ_ST, 32'h00000005);
      wr(`OFS_IRQ_EN, 32'h00000000);
      #1;
      chk({35'h0, irq}, 36'h0);
      wr(`OFS_IRQ_CLR, 32'h00000005);
      rd(`OFS_IRQ_ST, 32'h00000000);
      rd(`OFS_IRQ_CLR, 32'h00000000);
      $display("test parallel move done");
      wr(`OFS_MODE, 32'h00000001);
      i_core_feed.issue(16'h6408, 16'h1111, 16'h2222);
      rd(`OFS_IRQ_ST, 32'h00000008);
      rd(`OFS_Y0, 32'h00004000);
      wr(`OFS_MODE, 32'h00000000);
      ex(16'h6408, 16'h1111, 16'h2222, 1'b1);
      rd(`OFS_Y0, 32'h00001111);
      rd(`OFS_X0, 32'h00002222);
      rd(8'hfc, 32'h00000000);
      chk({35'h0, rerr}, 36'h1);
      ex(16'h6708, 16'h0123, 16'h8001, 1'b1);
      rd(`OFS_Y1, 32'h00000123);
      rd(8'h30, 32'h80010000);
      rd(8'h34, 32'h0000000f);
      ex(16'h3288, 16'h5a5a, 16'h0000, 1'b1);
      rd(8'h28, 32'h0a5c66b4);
      ex(16'h7ef9, 16'h0000, 16'h0000, 1'b0);
      rd(`OFS_Y0, 32'h00005a5a);
      $display("test dual read done");
      wrap_up;
   end
endmodule // testbench
